/* verification/chgsf_host.sv */
`timescale 1ns/100ps
`default_nettype none
module chgsf_host
  import chgsf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register strobe port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // The address is scrambled after each access so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* verification/chgsf_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module chgsf_regs_test
  import chgsf_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n;
  logic clk_en;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [21:0] core;
  logic safety_timer_reset;
  logic limit_irq_pulse;
  int err_total;
  int cmp_count;
  int mask_m;
  int irq_cnt = 0;
  int stp_cnt = 0;
  int junk;

  always #2.5 clk = ~clk;

  chgsf_regs i_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .otg_mode(core[21]), .input_source_type(core[20:18]), .charge_phase(core[17:16]),
    .power_good_flag(core[15]), .thermal_reg_flag(core[14]), .min_system_reg_flag(core[13]),
    .watchdog_expired(core[12]), .boost_fault(core[11]), .charge_fault_code(core[10:9]),
    .battery_overvoltage_fault(core[8]), .temp_zone_code(core[7:5]), .input_attached(core[4]),
    .input_voltage_limit_active(core[3]), .input_current_limit_active(core[2]),
    .finish_timer_running(core[1]), .input_overvoltage_flag(core[0]),
    .safety_timer_reset(safety_timer_reset), .limit_irq_pulse(limit_irq_pulse)
  );

  chgsf_host i_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  always @(posedge clk)
  begin
    if (limit_irq_pulse === 1'b1)
      irq_cnt++;
    if (safety_timer_reset === 1'b1)
      stp_cnt++;
  end

  // Expected register contents worked out from the live core levels and the tracked masks.
  function automatic logic [7:0] exp_reg(input int a);
    int s;
    int t;
    s = core[20:18];
    t = core[7:5];
    if (core[21])
      s = 7;
    else if (s == 4 || s == 7)
      s = 0;
    if (!(t == 5 || t == 6 || (!core[21] && (t == 2 || t == 3))))
      t = 0;
    case (a)
      8: return {s[2:0], core[17:13]};
      9: return {core[12:8], t[2:0]};
      10: return {core[4:2], 1'b0, core[1:0], mask_m[1:0]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    logic [7:0] d;
    logic ok;
    for (int a = 8; a < 12; a++)
    begin
      i_host.rd(a[7:0], d, ok);
      chk(ok, 1);
      chk(d, exp_reg(a));
    end
  endtask

  // Eight cycles cover the synchroniser, the register stage and any interrupt pulse.
  task automatic drive_core(input logic [21:0] v);
    @(posedge clk);
    core <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    logic [21:0] v;
    logic [7:0] d;
    logic ok;
    int base;
    rst_n = 1'b0;
    clk_en = 1'b1;
    core = 22'h0;
    mask_m = 0;
    err_total = 0;
    cmp_count = 0;
    junk = $urandom(25164);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check_all();
    // Every source and temperature code, in charging and in boost mode.
    for (int i = 0; i < 16; i++)
    begin
      v = $urandom;
      v[21] = i[3];
      v[20:18] = i[2:0];
      v[7:5] = i[2:0];
      drive_core(v);
      check_all();
    end
    for (int i = 0; i < 24; i++)
    begin
      drive_core($urandom);
      check_all();
    end
    i_host.wr(8'h08, 8'hff);
    i_host.wr(8'h09, 8'hff);
    i_host.wr(8'h0a, 8'hff);
    mask_m = 3;
    check_all();
    for (int m = 0; m < 4; m++)
    begin
      i_host.wr(8'h0a, m[7:0]);
      mask_m = m;
      drive_core(22'h0);
      base = irq_cnt;
      drive_core(22'h8);
      chk(irq_cnt - base, (m[1] == 1'b0) ? 1 : 0);
      base = irq_cnt;
      drive_core(22'hc);
      chk(irq_cnt - base, (m[0] == 1'b0) ? 1 : 0);
      drive_core(22'h0);
      base = irq_cnt;
      drive_core(22'hc);
      chk(irq_cnt - base, (m != 3) ? 1 : 0);
      check_all();
    end
    base = stp_cnt;
    i_host.wr(8'h0b, 8'h80);
    mask_m = 0;
    repeat (6) @(posedge clk);
    chk(stp_cnt - base, 1);
    check_all();
    i_host.rd(8'h20, d, ok);
    chk(d, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire

/* verilog/chgsf_defs.svh */
`ifndef CHGSF_DEFS_SVH
`define CHGSF_DEFS_SVH
// Contract
// - Source field: 000 none, 001 standard port, 010 charging port, 011 dedicated port.
// - Source field reads 101 for unknown adapter, 110 for non-standard adapter.
// - Source field reads 111 in OTG mode.
// - Charge phase: 00 idle, 01 pre-charge, 10 fast, 11 terminated.
// - Power-good flag reads 1 when input power is good.
// - Thermal-regulation flag reads 1 while in thermal regulation.
// - Minimum-system flag reads 1 while battery sits below minimum system voltage.
// - Watchdog fault bit reads 1 after watchdog expiry.
// - Boost fault bit reads 1 on any condition blocking boost.
// - Charge fault code 00 normal, 01 input fault.
// - Charge fault code 10 thermal shutdown, 11 safety timer expired.
// - Battery fault bit reads 1 on battery overvoltage.
// - Charging temperature zone: 000 normal, 010 warm, 011 cool, 101 cold, 110 hot.
// - Boost temperature zone uses only 000, 101 and 110.
// - Input-attached flag reads 1 while input supply is attached.
// - Flag reads 1 while input voltage limit loop is active.
// - Flag reads 1 while input current limit loop is active.
// - Flag reads 1 while the finish timer is counting.
// - Flag reads 1 while in input overvoltage.
// - Voltage-limit mask, default 0, set to 1 suppresses that interrupt pulse.
// - Current-limit mask, default 0, set to 1 suppresses that interrupt pulse.
// - Status fields are read-only; only the two mask bits take writes; the code also takes a write to the reset command bit.
// - Register reset restores defaults, resets safety timer, then self-clears.

`define CHGSF_OFF_CHG_STATUS 8'h08
`define CHGSF_OFF_FAULT_STATUS 8'h09
`define CHGSF_OFF_LIMIT_MASKS 8'h0a
`define CHGSF_OFF_REG_RESET 8'h0b
`define CHGSF_BIT_REG_RESET 7
`define CHGSF_MASK_RESET 2'h0
`define CHGSF_SRC_NONE 3'h0
`define CHGSF_SRC_SDP 3'h1
`define CHGSF_SRC_CDP 3'h2
`define CHGSF_SRC_DCP 3'h3
`define CHGSF_SRC_RSVD 3'h4
`define CHGSF_SRC_UNKNOWN 3'h5
`define CHGSF_SRC_NONSTD 3'h6
`define CHGSF_SRC_OTG 3'h7
`define CHGSF_TEMP_NORMAL 3'h0
`define CHGSF_TEMP_WARM 3'h2
`define CHGSF_TEMP_COOL 3'h3
`define CHGSF_TEMP_COLD 3'h5
`define CHGSF_TEMP_HOT 3'h6
`define CHGSF_CORE_WIDTH 22
`endif

/* verilog/chgsf_edge_pulse.sv */
`timescale 1ns/100ps
`default_nettype none
module chgsf_edge_pulse
  import chgsf_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Levels and their masks
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] mask,
  // One-cycle event
  output logic pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic pulse;
  } chgsf_edge_state_t;

  chgsf_edge_state_t st_r;
  chgsf_edge_state_t st_nxt;

  if (WIDTH < 2)
  begin : g_check
    $error("Edge pulse needs one bit for each limit loop.");
  end

  // A masked loop still updates its history, so unmasking later gives no stale event.
  always_comb
  begin
    st_nxt.prev = level;
    st_nxt.pulse = |(level & ~st_r.prev & ~mask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign pulse = st_r.pulse;

  a_vlimit_masked: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mask[0] && (level[1] == st_r.prev[1]) |=> !pulse)
    else $error("Masked voltage-limit event raised a pulse.");
  a_ilimit_masked: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mask[1] && (level[0] == st_r.prev[0]) |=> !pulse)
    else $error("Masked current-limit event raised a pulse.");
  a_limit_rise: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && |(level & ~st_r.prev & ~mask) |=> pulse ##1 (!pulse || !$past(clk_en) || $past(|(level & ~st_r.prev))))
    else $error("Unmasked limit rise gave no single pulse.");

endmodule
`default_nettype wire

/* verilog/chgsf_pkg.sv */
`include "chgsf_defs.svh"
package chgsf_pkg;

  typedef struct packed {
    logic [7:0] chg_status;
    logic [7:0] fault_status;
    logic [5:0] limit_live;
    logic [1:0] masks;
    logic reset_busy;
    logic timer_reset;
    logic [7:0] rdata;
    logic rvalid;
  } chgsf_state_t;

  // Codes the core should never produce read as no input rather than a stale class.
  function automatic logic [2:0] chgsf_src_code(input logic otg, input logic [2:0] raw);
    if (otg)
      return `CHGSF_SRC_OTG;
    else if (raw == `CHGSF_SRC_RSVD || raw == `CHGSF_SRC_OTG)
      return `CHGSF_SRC_NONE;
    else
      return raw;
  endfunction

  // Warm and cool have no meaning while boosting, so they fold to normal there.
  function automatic logic [2:0] chgsf_temp_code(input logic otg, input logic [2:0] raw);
    if (raw == `CHGSF_TEMP_COLD || raw == `CHGSF_TEMP_HOT)
      return raw;
    else if (!otg && (raw == `CHGSF_TEMP_WARM || raw == `CHGSF_TEMP_COOL))
      return raw;
    else
      return `CHGSF_TEMP_NORMAL;
  endfunction

endpackage

/* verilog/chgsf_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "chgsf_defs.svh"
module chgsf_regs
  import chgsf_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register access from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Live state from the charger core, asynchronous
  input wire logic otg_mode,
  input wire logic [2:0] input_source_type,
  input wire logic [1:0] charge_phase,
  input wire logic power_good_flag,
  input wire logic thermal_reg_flag,
  input wire logic min_system_reg_flag,
  input wire logic watchdog_expired,
  input wire logic boost_fault,
  input wire logic [1:0] charge_fault_code,
  input wire logic battery_overvoltage_fault,
  input wire logic [2:0] temp_zone_code,
  input wire logic input_attached,
  input wire logic input_voltage_limit_active,
  input wire logic input_current_limit_active,
  input wire logic finish_timer_running,
  input wire logic input_overvoltage_flag,
  // Outputs to the rest of the charger
  output logic safety_timer_reset,
  output logic limit_irq_pulse
);

  logic rst_meta_r;
  logic rst_sync_n_r;
  logic [`CHGSF_CORE_WIDTH-1:0] core_raw;
  logic [`CHGSF_CORE_WIDTH-1:0] core_s;
  logic otg_s;
  logic [2:0] src_s;
  logic [1:0] phase_s;
  logic pg_s;
  logic therm_s;
  logic minsys_s;
  logic wd_s;
  logic boost_s;
  logic [1:0] cfault_s;
  logic batov_s;
  logic [2:0] temp_s;
  logic attach_s;
  logic vlim_s;
  logic ilim_s;
  logic topoff_s;
  logic ovp_s;
  logic wr_masks;
  logic wr_reset;
  chgsf_state_t st_r;
  chgsf_state_t st_nxt;

  // Reset enters asynchronously but is released only on a clock edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  assign core_raw = {otg_mode, input_source_type, charge_phase, power_good_flag, thermal_reg_flag,
                     min_system_reg_flag, watchdog_expired, boost_fault, charge_fault_code,
                     battery_overvoltage_fault, temp_zone_code, input_attached,
                     input_voltage_limit_active, input_current_limit_active, finish_timer_running,
                     input_overvoltage_flag};

  // Bits of one multi-bit code may resolve on different edges; a read can see a one-cycle mix.
  chgsf_sync #(
    .WIDTH(`CHGSF_CORE_WIDTH)
  ) u_core_sync (
    .clk(clk),
    .rst_n(rst_sync_n_r),
    .clk_en(clk_en),
    .d(core_raw),
    .q(core_s)
  );

  assign {otg_s, src_s, phase_s, pg_s, therm_s, minsys_s, wd_s, boost_s, cfault_s, batov_s, temp_s,
          attach_s, vlim_s, ilim_s, topoff_s, ovp_s} = core_s;

  assign wr_masks = reg_wr && (reg_addr == `CHGSF_OFF_LIMIT_MASKS);
  assign wr_reset = reg_wr && (reg_addr == `CHGSF_OFF_REG_RESET) && reg_wdata[`CHGSF_BIT_REG_RESET];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.timer_reset = 1'b0;
    st_nxt.chg_status = {chgsf_src_code(otg_s, src_s), phase_s, pg_s, therm_s, minsys_s};
    st_nxt.fault_status = {wd_s, boost_s, cfault_s, batov_s, chgsf_temp_code(otg_s, temp_s)};
    st_nxt.limit_live = {attach_s, vlim_s, ilim_s, 1'b0, topoff_s, ovp_s};
    // Only the masks and the reset command are writable; other writes fall away.
    if (st_r.reset_busy)
    begin
      st_nxt.masks = `CHGSF_MASK_RESET;
      st_nxt.timer_reset = 1'b1;
      st_nxt.reset_busy = 1'b0;
    end
    else if (wr_reset)
      st_nxt.reset_busy = 1'b1;
    else if (wr_masks)
      st_nxt.masks = reg_wdata[1:0];
    if (reg_rd)
    begin
      st_nxt.rvalid = 1'b1;
      unique case (reg_addr)
        `CHGSF_OFF_CHG_STATUS: st_nxt.rdata = st_r.chg_status;
        `CHGSF_OFF_FAULT_STATUS: st_nxt.rdata = st_r.fault_status;
        `CHGSF_OFF_LIMIT_MASKS: st_nxt.rdata = {st_r.limit_live, st_r.masks};
        `CHGSF_OFF_REG_RESET: st_nxt.rdata = {st_r.reset_busy, 7'h00};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  // Mask bit 1 gates the voltage loop (level bit 0), mask bit 0 the current loop.
  chgsf_edge_pulse #(
    .WIDTH(2)
  ) u_limit_irq (
    .clk(clk),
    .rst_n(rst_sync_n_r),
    .clk_en(clk_en),
    .level({ilim_s, vlim_s}),
    .mask({st_r.masks[0], st_r.masks[1]}),
    .pulse(limit_irq_pulse)
  );

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign safety_timer_reset = st_r.timer_reset;

  a_src_port: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && !otg_s && !src_s[2] |=> st_r.chg_status[7:5] == $past(src_s))
    else $error("Port source code not reported.");
  a_src_adapter: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && !otg_s && (src_s == `CHGSF_SRC_UNKNOWN || src_s == `CHGSF_SRC_NONSTD)
    |=> st_r.chg_status[7:5] == $past(src_s))
    else $error("Adapter source code not reported.");
  a_src_otg: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && otg_s |=> st_r.chg_status[7:5] == `CHGSF_SRC_OTG)
    else $error("Source code not OTG while boosting.");
  a_phase_track: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.chg_status[4:3] == $past(phase_s))
    else $error("Charge phase not tracked.");
  a_power_good: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.chg_status[2] == $past(pg_s))
    else $error("Power-good flag not tracked.");
  a_thermal_reg: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.chg_status[1] == $past(therm_s))
    else $error("Thermal flag not tracked.");
  a_min_system: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.chg_status[0] == $past(minsys_s))
    else $error("Minimum-system flag not tracked.");
  a_watchdog_bit: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.fault_status[7] == $past(wd_s))
    else $error("Watchdog fault not tracked.");
  a_boost_bit: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.fault_status[6] == $past(boost_s))
    else $error("Boost fault not tracked.");
  a_input_fault: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && !cfault_s[1] |=> st_r.fault_status[5:4] == $past(cfault_s))
    else $error("Input fault code wrong.");
  a_thermal_timer: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && cfault_s[1] |=> st_r.fault_status[5:4] == $past(cfault_s))
    else $error("Thermal or timer fault code wrong.");
  a_battery_ov: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.fault_status[3] == $past(batov_s))
    else $error("Battery fault not tracked.");
  a_temp_buck: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && !otg_s && (temp_s inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h6}) |=> st_r.fault_status[2:0] == $past(temp_s))
    else $error("Charging temperature zone wrong.");
  a_temp_boost: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && otg_s |=> st_r.fault_status[2:0] inside {3'h0, 3'h5, 3'h6})
    else $error("Boost temperature zone outside allowed set.");
  a_attached: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.limit_live[5] == $past(attach_s))
    else $error("Input-attached flag not tracked.");
  a_vlimit_flag: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.limit_live[4] == $past(vlim_s))
    else $error("Voltage-limit flag not tracked.");
  a_ilimit_flag: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.limit_live[3] == $past(ilim_s))
    else $error("Current-limit flag not tracked.");
  a_finish_timer: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.limit_live[1] == $past(topoff_s))
    else $error("Finish-timer flag not tracked.");
  a_input_ovp: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en |=> st_r.limit_live[0] == $past(ovp_s))
    else $error("Input overvoltage flag not tracked.");
  a_masks_hold: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && !wr_masks && !st_r.reset_busy |=> st_r.masks == $past(st_r.masks))
    else $error("Masks changed without a write.");
  a_reg_reset: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && wr_reset && !st_r.reset_busy |=> st_r.reset_busy ##1 (!clk_en || $past(!clk_en) ||
    (st_r.masks == `CHGSF_MASK_RESET && safety_timer_reset && !st_r.reset_busy)))
    else $error("Register reset did not restore and self-clear.");
  a_read_live: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
    clk_en && reg_rd && reg_addr == `CHGSF_OFF_CHG_STATUS |=> reg_rvalid && reg_rdata == $past(st_r.chg_status))
    else $error("Status read returned wrong value.");

endmodule
`default_nettype wire

/* verilog/chgsf_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module chgsf_sync
  import chgsf_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } chgsf_sync_state_t;

  chgsf_sync_state_t st_r;
  chgsf_sync_state_t st_nxt;

  if (WIDTH < 1)
  begin : g_check
    $error("Synchroniser width must be at least one.");
  end

  always_comb
  begin
    st_nxt.meta = d;
    st_nxt.q = st_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign q = st_r.q;

endmodule
`default_nettype wire
